/* File: bench/cathode_amp_model.sv */
// Purpose: Cathode amplifier feedback model for the gray scale servo bench.
// Assumes: Cathode current follows the latch of the loop being served.
// Notes: The comparator levels follow the error with a deadband.
`timescale 1ns/1ns
`default_nettype none
module cathode_amp_model #(
  parameter int DEADBAND = 1,
  parameter int OFS_TARGET = 48
) (
  input wire logic [20:0] dc_dac_i,
  input wire logic [20:0] gain_dac_i,
  input wire logic [6:0] offset_dac_i,
  input wire logic [20:0] ref_dac_i,
  input wire logic black_pulse_i,
  input wire logic [1:0] channel_i,
  input wire logic field_flyback_i,
  output logic upper_o,
  output logic lower_o
);
  int err;
  int c;
  // The error is the reference current less the current that comes back.
  always_comb begin
    c = (channel_i > 2'h2) ? 0 : int'(channel_i);
    if (field_flyback_i) begin
      err = OFS_TARGET - int'(offset_dac_i);
    end else if (black_pulse_i) begin
      err = int'(ref_dac_i[7*c +: 7]) - int'(dc_dac_i[7*c +: 7]);
    end else begin
      err = int'(ref_dac_i[7*c +: 7]) - int'(gain_dac_i[7*c +: 7]);
    end
    upper_o = err > DEADBAND;
    lower_o = err < -DEADBAND;
  end
endmodule // cathode_amp_model
`default_nettype wire

/* File: bench/cathode_gray_scale_servo_tb_top.sv */
// Purpose: Self-checking bench for the cathode gray scale servo.
// Assumes: The first sampling line starts at vsupp, the next two at hsync.
// Notes: The model predicts one servo step per loop per sampling frame.
`timescale 1ns/1ns
`default_nettype none
module cathode_gray_scale_servo_tb_top
  import gray_servo_pkg::*;
;
  localparam int DB = 1;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic vsupp_end_i = 1'b0;
  logic hsync_i = 1'b0;
  logic field_flyback_i = 1'b0;
  logic upper_error_comparator_i, lower_error_comparator_i;
  logic [20:0] dc_dac_o, gain_dac_o, ref_dac_o;
  logic [6:0] offset_dac_o, contrast_dac_o, brightness_dac_o;
  logic bright_pulse_o, black_pulse_o;
  logic screen_grid_control_up_o, screen_grid_control_down_o;
  logic [1:0] channel_o;
  int bad_count = 0;
  int check_count = 0;
  int inten[3], gain[3], dc[3];
  int ctr, gap;
  logic [31:0] rd;
  logic [31:0] seed = 32'h3F;

  gray_scale_servo dut (.mclk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .vsupp_end_i,
    .hsync_i, .field_flyback_i, .upper_error_comparator_i, .lower_error_comparator_i,
    .dc_dac_o, .gain_dac_o, .offset_dac_o, .ref_dac_o, .contrast_dac_o, .brightness_dac_o,
    .bright_pulse_o, .black_pulse_o, .channel_o, .screen_grid_control_up_o,
    .screen_grid_control_down_o);
  cathode_amp_model #(.DEADBAND(DB), .OFS_TARGET(48)) amp (.dc_dac_i(dc_dac_o),
    .gain_dac_i(gain_dac_o), .offset_dac_i(offset_dac_o), .ref_dac_i(ref_dac_o),
    .black_pulse_i(black_pulse_o), .channel_i(channel_o), .field_flyback_i(field_flyback_i),
    .upper_o(upper_error_comparator_i), .lower_o(lower_error_comparator_i));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int stepv(input int v, input int t);
    if (t - v > DB) return (v < 127) ? v + 1 : v;
    if (v - t > DB) return (v > 0) ? v - 1 : v;
    return v;
  endfunction
  function automatic logic [31:0] pack(input int a[3]);
    return {11'h0, 7'(a[2]), 7'(a[1]), 7'(a[0])};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // The request stands until waitrequest is sampled low; one idle edge follows.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    check(n, 32'h2);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask
  task automatic wait_for(input bit black);
    gap = 0;
    while ((black ? black_pulse_o : bright_pulse_o) !== 1'b1 && gap < LINE_CYCLES) begin
      @(posedge mclk_i);
      gap++;
    end
  endtask

  task automatic frame(input bit bright_on, input bit run, input bit mon);
    fork
      for (int l = 0; l < 4; l++) begin
        if (l == 0) begin
          vsupp_end_i <= 1'b1;
        end else begin
          hsync_i <= 1'b1;
        end
        repeat (40) @(posedge mclk_i);
        vsupp_end_i <= 1'b0;
        hsync_i <= 1'b0;
        if (l < 3) begin
          repeat (LINE_CYCLES - 40) @(posedge mclk_i);
        end
      end
      for (int k = 0; k < 3 && mon; k++) begin
        wait_for(1'b0);
        check(channel_o, k);
        check(ref_dac_o[7*k +: 7], inten[k]);
        check(contrast_dac_o, ctr);
        wait_for(1'b1);
        check(bright_pulse_o, 1'b0);
        check(gap >= 3190 && gap <= 3210, 1);
        check(ref_dac_o[7*k +: 7], inten[k] / 10);
      end
    join
    repeat (10) @(posedge mclk_i);
    check(black_pulse_o, 1'b0);
    for (int c = 0; c < 3 && run; c++) begin
      if (bright_on) gain[c] = stepv(gain[c], inten[c]);
      dc[c] = stepv(dc[c], inten[c] / 10);
    end
    check({11'h0, gain_dac_o}, pack(gain));
    check({11'h0, dc_dac_o}, pack(dc));
    rdchk(OFS_GAIN_LATCH, pack(gain));
    rdchk(OFS_DC_LATCH, pack(dc));
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    $display("ERROR t=%0t seen=%h expected=%h", $time, 32'h0, 32'h1);
    wrap_up();
  end

  initial begin
    ctr = 32'h40;
    for (int c = 0; c < 3; c++) begin
      inten[c] = 32'h20;
      gain[c] = 32'h40;
      dc[c] = 32'h40;
    end
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (int c = 0; c < 3; c++) rdchk(OFS_INTENSITY_R + 8'(4 * c), 32'h20);
    rdchk(OFS_CONTRAST, 32'h40);
    rdchk(OFS_BRIGHTNESS, 32'h40);
    rdchk(OFS_LIMITS, 32'h7008);
    rdchk(OFS_DC_LATCH, pack(dc));
    rdchk(OFS_OFFSET_LATCH, 32'h40);
    rdchk(8'h30, 32'h0);
    wr(8'h30, 32'h5);
    bus(1'b1, OFS_CONTRAST, 32'h11, 4'h0);
    rdchk(OFS_CONTRAST, 32'h40);
    wr(OFS_BRIGHTNESS, 32'h2A);
    @(posedge mclk_i);
    check(brightness_dac_o, 32'h2A);
    ctr = 32'h55;
    wr(OFS_CONTRAST, ctr);
    wr(OFS_INTENSITY_R, 32'h7F);
    repeat (2) @(posedge mclk_i);
    check({screen_grid_control_up_o, screen_grid_control_down_o}, 32'h2);
    rdchk(OFS_STATUS, 32'h1);
    wr(OFS_INTENSITY_R, 32'h02);
    repeat (2) @(posedge mclk_i);
    check({screen_grid_control_up_o, screen_grid_control_down_o}, 32'h1);
    rdchk(OFS_STATUS, 32'h2);
    wr(OFS_LIMITS, 32'h7001);
    repeat (2) @(posedge mclk_i);
    check({screen_grid_control_up_o, screen_grid_control_down_o}, 32'h0);
    rdchk(OFS_LIMITS, 32'h7001);
    for (int c = 0; c < 3; c++) begin
      inten[c] = 32'h10 + xs() % 32'h58;
      wr(OFS_INTENSITY_R + 8'(4 * c), inten[c]);
    end
    wr(OFS_CONTROL, 32'h0);
    field_flyback_i <= 1'b1;
    repeat (400) @(posedge mclk_i);
    field_flyback_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check(offset_dac_o, stepv(32'h40, 48));
    check({11'h0, gain_dac_o}, pack(gain));
    frame(1'b1, 1'b1, 1'b1);
    wr(OFS_CONTROL, 32'h2);
    frame(1'b0, 1'b1, 1'b0);
    wr(OFS_CONTROL, 32'h1);
    frame(1'b1, 1'b0, 1'b0);
    inten[1] = 32'h10 + xs() % 32'h58;
    wr(OFS_INTENSITY_G, inten[1]);
    wr(OFS_CONTROL, 32'h0);
    rdchk(OFS_CONTROL, 32'h0);
    wrap_up();
  end
endmodule // cathode_gray_scale_servo_tb_top
`default_nettype wire

/* File: core/gray_scale_servo.sv */
// Purpose: Digital control of the auto gray scale cathode servo loops.
// Assumes: Comparator and timing pins are asynchronous; host uses Avalon-MM.
// Notes: Latches drive external 7-bit converters through one register stage.
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Sample three lines after vertical suppression
// - First half bright, second half dark
// - Six loops: three dark, three gain
// - Latches hold values, feed 7-bit converters
// - Three intensity latches give references
// - Bright pulse amplitude follows contrast
// - Gain loop matches bright reference
// - Count up above, down below, else hold
// - Dark reference is intensity over ten
// - Black pulse; dark loop matches reference
// - Load copies counter into served latch
// - Backload copies latch into counter first
// - Timing-driven sequencer addresses latches
// - Brightness shifts all pedestals equally
// - Contrast word sets bright pulse level
// - Freeze bit holds loops unchanged
// - Offset loop runs in field flyback
// - Limit flags request screen grid adjust
module gray_scale_servo
  import gray_servo_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic vsupp_end_i,
  input wire logic hsync_i,
  input wire logic field_flyback_i,
  input wire logic upper_error_comparator_i,
  input wire logic lower_error_comparator_i,
  output logic [20:0] dc_dac_o,
  output logic [20:0] gain_dac_o,
  output logic [6:0] offset_dac_o,
  output logic [20:0] ref_dac_o,
  output logic [6:0] contrast_dac_o,
  output logic [6:0] brightness_dac_o,
  output logic bright_pulse_o,
  output logic black_pulse_o,
  output logic [1:0] channel_o,
  output logic screen_grid_control_up_o,
  output logic screen_grid_control_down_o
);
  logic [6:0] intensity_ff [3];
  logic [6:0] dc_ff [3];
  logic [6:0] gain_ff [3];
  logic [6:0] offset_ff;
  logic [6:0] contrast_ff;
  logic [6:0] brightness_ff;
  logic freeze_ff;
  logic bright_off_ff;
  logic [6:0] limit_hi_ff;
  logic [6:0] limit_lo_ff;
  logic lim_up_ff;
  logic lim_dn_ff;
  logic vsupp_s;
  logic hsync_s;
  logic flyback_s;
  logic up_s;
  logic dn_s;
  logic vsupp_d_ff;
  logic hsync_d_ff;
  logic flyback_d_ff;
  logic sampling_ff;
  logic [1:0] line_ff;
  logic [12:0] pos_ff;
  logic [1:0] loop_ch_ff;
  logic loop_dark_ff;
  logic loop_offset_ff;
  step_t step_ff;
  logic [5:0] step_cnt_ff;
  logic [6:0] sel_latch;
  logic start_bright;
  logic start_dark;
  logic start_offset;
  logic bus_hit;
  servo_step_if st ();
  servo_counter u_counter (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .st(st)
  );
  pin_sync u_sync_vs (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pin_i(vsupp_end_i),
    .level_o(vsupp_s));
  pin_sync u_sync_hs (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pin_i(hsync_i),
    .level_o(hsync_s));
  pin_sync u_sync_fb (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pin_i(field_flyback_i),
    .level_o(flyback_s));
  pin_sync u_sync_up (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .pin_i(upper_error_comparator_i), .level_o(up_s));
  pin_sync u_sync_dn (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .pin_i(lower_error_comparator_i), .level_o(dn_s));
  function automatic logic [6:0] dark_ref(input logic [6:0] val);
    dark_ref = val / {3'h0, DARK_DIVISOR};
  endfunction
  // Edge detectors and line counting over the three sampling lines.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vsupp_d_ff <= 1'b0;
      hsync_d_ff <= 1'b0;
      flyback_d_ff <= 1'b0;
    end else begin
      vsupp_d_ff <= vsupp_s;
      hsync_d_ff <= hsync_s;
      flyback_d_ff <= flyback_s;
    end
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sampling_ff <= 1'b0;
      line_ff <= 2'h0;
      pos_ff <= 13'h0000;
    end else if (vsupp_s && !vsupp_d_ff) begin
      sampling_ff <= 1'b1;
      line_ff <= 2'h0;
      pos_ff <= 13'h0000;
    end else if (sampling_ff && hsync_s && !hsync_d_ff && pos_ff != 13'h0000) begin
      pos_ff <= 13'h0000;
      if (line_ff == 2'(SAMPLE_LINES - 1)) begin
        sampling_ff <= 1'b0;
      end else begin
        line_ff <= line_ff + 2'h1;
      end
    end else if (sampling_ff && pos_ff != 13'(LINE_CYCLES - 1)) begin
      pos_ff <= pos_ff + 13'h0001;
    end
  end
  assign start_bright = sampling_ff && pos_ff == 13'h0001;
  assign start_dark = sampling_ff && pos_ff == 13'(HALF_LINE_CYCLES);
  assign start_offset = flyback_s && !flyback_d_ff;
  // Sequencer: backload, adjust, load for the addressed loop.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_ff <= PH_IDLE;
      step_cnt_ff <= 6'h00;
      loop_ch_ff <= 2'h0;
      loop_dark_ff <= 1'b0;
      loop_offset_ff <= 1'b0;
    end else begin
      unique case (step_ff)
        PH_IDLE: begin
          if (!freeze_ff && start_bright && !bright_off_ff) begin
            step_ff <= PH_BACKLOAD;
            loop_ch_ff <= line_ff;
            loop_dark_ff <= 1'b0;
            loop_offset_ff <= 1'b0;
          end else if (!freeze_ff && start_dark) begin
            step_ff <= PH_BACKLOAD;
            loop_ch_ff <= line_ff;
            loop_dark_ff <= 1'b1;
            loop_offset_ff <= 1'b0;
          end else if (!freeze_ff && start_offset) begin
            step_ff <= PH_BACKLOAD;
            loop_offset_ff <= 1'b1;
          end
        end
        PH_BACKLOAD: begin
          step_ff <= PH_ADJUST;
          step_cnt_ff <= 6'h00;
        end
        PH_ADJUST: begin
          step_cnt_ff <= step_cnt_ff + 6'h01;
          if (step_cnt_ff == 6'(STEP_CYCLES - 1)) begin
            step_ff <= PH_LOAD;
          end
        end
        PH_LOAD: begin
          step_ff <= PH_IDLE;
        end
      endcase
    end
  end
  always_comb begin
    if (loop_offset_ff) begin
      sel_latch = offset_ff;
    end else if (loop_dark_ff) begin
      sel_latch = dc_ff[loop_ch_ff];
    end else begin
      sel_latch = gain_ff[loop_ch_ff];
    end
  end
  assign st.backload = step_ff == PH_BACKLOAD;
  assign st.backload_val = sel_latch;
  // The decision waits for the last adjust cycle so that the synchronised comparator
  // levels reflect the reference pulse of this period, not the previous one.
  assign st.count_en = step_ff == PH_ADJUST && step_cnt_ff == 6'(STEP_CYCLES - 1);
  assign st.up = up_s;
  assign st.down = dn_s && !up_s;
  // Converter latches; written only by load steps, read back by the host.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        dc_ff[i] <= RST_LATCH;
        gain_ff[i] <= RST_LATCH;
      end
      offset_ff <= RST_LATCH;
    end else if (step_ff == PH_LOAD && !freeze_ff) begin
      if (loop_offset_ff) begin
        offset_ff <= st.count;
      end else if (loop_dark_ff) begin
        dc_ff[loop_ch_ff] <= st.count;
      end else begin
        gain_ff[loop_ch_ff] <= st.count;
      end
    end
  end
  // Host registers.
  assign bus_hit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        intensity_ff[i] <= RST_INTENSITY;
      end
      contrast_ff <= RST_CONTRAST;
      brightness_ff <= RST_BRIGHTNESS;
      freeze_ff <= 1'b0;
      bright_off_ff <= 1'b0;
      limit_hi_ff <= RST_LIMIT_HI;
      limit_lo_ff <= RST_LIMIT_LO;
    end else if (bus_hit) begin
      unique case (avs_address_i)
        OFS_INTENSITY_R: intensity_ff[0] <= avs_writedata_i[6:0];
        OFS_INTENSITY_G: intensity_ff[1] <= avs_writedata_i[6:0];
        OFS_INTENSITY_B: intensity_ff[2] <= avs_writedata_i[6:0];
        OFS_CONTRAST: contrast_ff <= avs_writedata_i[6:0];
        OFS_BRIGHTNESS: brightness_ff <= avs_writedata_i[6:0];
        OFS_CONTROL: begin
          freeze_ff <= avs_writedata_i[CTRL_FREEZE_BIT];
          bright_off_ff <= avs_writedata_i[CTRL_BRIGHT_OFF_BIT];
        end
        OFS_LIMITS: begin
          limit_lo_ff <= avs_writedata_i[6:0];
          limit_hi_ff <= avs_writedata_i[14:8];
        end
        default: begin
        end
      endcase
    end
  end
  // Limit flags follow the reference words.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim_up_ff <= 1'b0;
      lim_dn_ff <= 1'b0;
    end else begin
      lim_up_ff <= intensity_ff[0] > limit_hi_ff || intensity_ff[1] > limit_hi_ff ||
        intensity_ff[2] > limit_hi_ff;
      lim_dn_ff <= intensity_ff[0] < limit_lo_ff || intensity_ff[1] < limit_lo_ff ||
        intensity_ff[2] < limit_lo_ff;
    end
  end
  // Bus slave: one wait cycle, read data registered.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        unique case (avs_address_i)
          OFS_INTENSITY_R: avs_readdata_o <= {25'h0, intensity_ff[0]};
          OFS_INTENSITY_G: avs_readdata_o <= {25'h0, intensity_ff[1]};
          OFS_INTENSITY_B: avs_readdata_o <= {25'h0, intensity_ff[2]};
          OFS_CONTRAST: avs_readdata_o <= {25'h0, contrast_ff};
          OFS_BRIGHTNESS: avs_readdata_o <= {25'h0, brightness_ff};
          OFS_CONTROL: avs_readdata_o <= {30'h0, bright_off_ff, freeze_ff};
          OFS_STATUS: avs_readdata_o <= {30'h0, lim_dn_ff, lim_up_ff};
          OFS_LIMITS: avs_readdata_o <= {17'h0, limit_hi_ff, 1'b0, limit_lo_ff};
          OFS_DC_LATCH: avs_readdata_o <= {11'h0, dc_ff[2], dc_ff[1], dc_ff[0]};
          OFS_GAIN_LATCH: avs_readdata_o <= {11'h0, gain_ff[2], gain_ff[1], gain_ff[0]};
          OFS_OFFSET_LATCH: avs_readdata_o <= {25'h0, offset_ff};
          default: avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end
  // Registered analog drive words.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dc_dac_o <= {3{RST_LATCH}};
      gain_dac_o <= {3{RST_LATCH}};
      offset_dac_o <= RST_LATCH;
      ref_dac_o <= 21'h000000;
      contrast_dac_o <= RST_CONTRAST;
      brightness_dac_o <= RST_BRIGHTNESS;
      bright_pulse_o <= 1'b0;
      black_pulse_o <= 1'b0;
      channel_o <= 2'h0;
      screen_grid_control_up_o <= 1'b0;
      screen_grid_control_down_o <= 1'b0;
    end else begin
      dc_dac_o <= {dc_ff[2], dc_ff[1], dc_ff[0]};
      gain_dac_o <= {gain_ff[2], gain_ff[1], gain_ff[0]};
      offset_dac_o <= offset_ff;
      if (sampling_ff && pos_ff >= 13'(HALF_LINE_CYCLES)) begin
        ref_dac_o <= {dark_ref(intensity_ff[2]), dark_ref(intensity_ff[1]),
          dark_ref(intensity_ff[0])};
      end else begin
        ref_dac_o <= {intensity_ff[2], intensity_ff[1], intensity_ff[0]};
      end
      contrast_dac_o <= contrast_ff;
      brightness_dac_o <= brightness_ff;
      bright_pulse_o <= sampling_ff && pos_ff < 13'(HALF_LINE_CYCLES);
      black_pulse_o <= sampling_ff && pos_ff >= 13'(HALF_LINE_CYCLES);
      channel_o <= line_ff;
      screen_grid_control_up_o <= lim_up_ff;
      screen_grid_control_down_o <= lim_dn_ff;
    end
  end
  property p_freeze_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (freeze_ff && step_ff == PH_IDLE) |=> $stable(dc_ff[0]) && $stable(gain_ff[0]);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("latch moved while frozen");
  sequence s_backload;
    step_ff == PH_BACKLOAD;
  endsequence
  sequence s_adjust;
    step_ff == PH_ADJUST [*8];
  endsequence
  property p_step_order;
    @(posedge mclk_i) disable iff (!arst_n_i)
      s_backload |=> s_adjust;
  endproperty
  a_step_order: assert property (p_step_order) else $error("adjust did not follow backload");
  property p_load_copy;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (step_ff == PH_LOAD && !freeze_ff && !loop_offset_ff && loop_dark_ff)
      |=> dc_ff[$past(loop_ch_ff)] == $past(st.count);
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not copy counter");
  property p_halves;
    @(posedge mclk_i) disable iff (!arst_n_i)
      ##1 !(bright_pulse_o && black_pulse_o);
  endproperty
  a_halves: assert property (p_halves) else $error("bright and black overlap");
  property p_dark_ref;
    @(posedge mclk_i) disable iff (!arst_n_i)
      black_pulse_o |-> ref_dac_o[6:0] == dark_ref($past(intensity_ff[0]));
  endproperty
  a_dark_ref: assert property (p_dark_ref) else $error("dark reference wrong");
  property p_limit_flag;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (intensity_ff[0] > limit_hi_ff) |-> ##2 screen_grid_control_up_o;
  endproperty
  a_limit_flag: assert property (p_limit_flag) else $error("upward flag missing");
endmodule // gray_scale_servo
`default_nettype wire

/* File: core/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to mclk_i.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_o <= s3_ff;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: core/servo_counter.sv */
// Purpose: 7-bit saturating up/down loop counter.
// Assumes: Up and down never both high.
// Notes: Backload overrides counting.
`timescale 1ns/1ns
`default_nettype none
module servo_counter
  import gray_servo_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  servo_step_if.cnt st
);
  logic [6:0] cnt_ff;
  assign st.count = cnt_ff;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= RST_LATCH;
    end else if (st.backload) begin
      cnt_ff <= st.backload_val;
    end else if (st.count_en && st.up && cnt_ff != 7'h7F) begin
      cnt_ff <= cnt_ff + 7'h01;
    end else if (st.count_en && st.down && cnt_ff != 7'h00) begin
      cnt_ff <= cnt_ff - 7'h01;
    end
  end
  property p_sat_top;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!st.backload && cnt_ff == 7'h7F) |=> cnt_ff == 7'h7F;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("counter wrapped at top");
  property p_sat_bot;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!st.backload && cnt_ff == 7'h00) |=> cnt_ff == 7'h00;
  endproperty
  a_sat_bot: assert property (p_sat_bot) else $error("counter wrapped at bottom");
  property p_deadband;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!st.backload && !st.up && !st.down) |=> $stable(cnt_ff);
  endproperty
  a_deadband: assert property (p_deadband) else $error("counter moved in deadband");
  property p_backload;
    @(posedge mclk_i) disable iff (!arst_n_i)
      st.backload |=> cnt_ff == $past(st.backload_val);
  endproperty
  a_backload: assert property (p_backload) else $error("backload value lost");
endmodule // servo_counter
`default_nettype wire

/* File: include/gray_servo_pkg.sv */
// Purpose: Shared constants and types for the cathode gray scale servo.
// Assumes: Avalon-MM word addressing in bytes, 32-bit data.
// Notes: Offsets are byte addresses.
package gray_servo_pkg;
  localparam int unsigned DAC_W = 7;
  localparam logic [7:0] OFS_INTENSITY_R = 8'h00;
  localparam logic [7:0] OFS_INTENSITY_G = 8'h04;
  localparam logic [7:0] OFS_INTENSITY_B = 8'h08;
  localparam logic [7:0] OFS_CONTRAST = 8'h0C;
  localparam logic [7:0] OFS_BRIGHTNESS = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_LIMITS = 8'h1C;
  localparam logic [7:0] OFS_DC_LATCH = 8'h20;
  localparam logic [7:0] OFS_GAIN_LATCH = 8'h24;
  localparam logic [7:0] OFS_OFFSET_LATCH = 8'h28;
  localparam int unsigned CTRL_FREEZE_BIT = 0;
  localparam int unsigned CTRL_BRIGHT_OFF_BIT = 1;
  localparam int unsigned STAT_LIMIT_UP_BIT = 0;
  localparam int unsigned STAT_LIMIT_DN_BIT = 1;
  localparam logic [6:0] RST_INTENSITY = 7'h20;
  localparam logic [6:0] RST_CONTRAST = 7'h40;
  localparam logic [6:0] RST_BRIGHTNESS = 7'h40;
  localparam logic [6:0] RST_LATCH = 7'h40;
  localparam logic [6:0] RST_LIMIT_HI = 7'h70;
  localparam logic [6:0] RST_LIMIT_LO = 7'h08;
  localparam logic [3:0] DARK_DIVISOR = 4'hA;
  localparam int unsigned SAMPLE_LINES = 3;
  localparam int unsigned LINE_US = 64;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned LINE_CYCLES = LINE_US * CLK_MHZ;
  localparam int unsigned HALF_LINE_CYCLES = LINE_CYCLES / 2;
  localparam int unsigned STEP_CYCLES = 64;
  typedef enum logic [1:0] {PH_BACKLOAD, PH_ADJUST, PH_LOAD, PH_IDLE} step_t;
endpackage

/* File: include/servo_step_if.sv */
// Purpose: Carrier between sequencer and loop counter.
// Assumes: One clock domain.
// Notes: Backload and count enable are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
interface servo_step_if;
  logic backload;
  logic [6:0] backload_val;
  logic count_en;
  logic up;
  logic down;
  logic [6:0] count;
  modport seq (output backload, output backload_val, output count_en, output up,
    output down, input count);
  modport cnt (input backload, input backload_val, input count_en, input up,
    input down, output count);
endinterface
`default_nettype wire
